// File: src/motor_system_status_regs.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Status one bits 31..16 report supply voltage in tenths of a volt.
// R2 - Status one bits 15..1 report decoded speed request, 32767 is full.
// R3 - Status one bit 0 is set when serial mode came from pin sequence.
// R4 - Status two bits 31..28 show the current control state code, kept current.
// R5 - State codes follow the fixed table; unlisted codes read as not applicable.
// R6 - Status two bit 17 reads one on self-test failure, zero on pass.
// R7 - Status two bits 15..0 report electrical speed in tenths of a hertz.
// R8 - Status registers sit at indexes E4, EA, EC and reset to zero.
// R9 - Host leaves other offsets of this group untouched.
// R10 - Status three bits 31..16 report bus current in 1/256 ampere.
// R11 - Status three bits 15..0 report input power in 1/64 watt.
// R12 - Writes to status registers do nothing; reserved bits read as zero.
module motor_system_status_regs (
  input wire logic core_clk, // system clock, 200 MHz
  input wire logic reset, // synchronous reset, active high
  input wire logic [11:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [31:0] reg_rdata, // read data, valid the cycle after reg_rd
  output logic irq, // level interrupt
  input wire logic [15:0] supply_voltage_reading, // supply in tenths of a volt
  input wire logic [14:0] speed_request, // decoded speed request
  input wire logic serial_entry, // serial mode entered by pin sequence
  input wire logic [3:0] state_code, // control state code
  input wire logic selftest_fail_flag, // self-test failed
  input wire logic [15:0] motor_speed, // electrical speed in tenths of a hertz
  input wire logic [15:0] bus_current_reading, // bus current in 1/256 A
  input wire logic [15:0] input_power_reading // input power in 1/64 W
);

  ////////////////////////////////////////////////////////////////////////////////

  status_snapshot_if snap_bus ();

  motor_status_pkg::reg_sel_t rd_sel;
  motor_status_pkg::reg_sel_t wr_sel;
  logic [31:0] read_value;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic clear_hit;

  status_sampler sampler (
    .core_clk(core_clk),
    .reset(reset),
    .supply_voltage_reading(supply_voltage_reading),
    .speed_request(speed_request),
    .serial_entry(serial_entry),
    .state_code(state_code),
    .selftest_fail_flag(selftest_fail_flag),
    .motor_speed(motor_speed),
    .bus_current_reading(bus_current_reading),
    .input_power_reading(input_power_reading),
    .bus(snap_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////

  assign rd_sel = motor_status_pkg::decode_reg(reg_addr); // [R8]
  assign wr_sel = motor_status_pkg::decode_reg(reg_addr);

  // Writes reach only the interrupt registers; anything else is dropped silently.
  assign clear_hit = reg_wr && wr_sel == motor_status_pkg::sel_irq_status; // [R12]

  always_comb begin
    read_value = motor_status_pkg::STATUS_RESET; // [R12]
    case (rd_sel)
      motor_status_pkg::sel_status_one: begin
        read_value[motor_status_pkg::VOLT_MSB:motor_status_pkg::VOLT_LSB] =
          snap_bus.supply_voltage_reading; // [R1]
        read_value[motor_status_pkg::SPEED_CMD_MSB:motor_status_pkg::SPEED_CMD_LSB] =
          snap_bus.speed_request; // [R2]
        read_value[motor_status_pkg::SERIAL_ENTRY_BIT] = snap_bus.serial_entry; // [R3]
      end
      motor_status_pkg::sel_status_two: begin
        read_value[motor_status_pkg::STATE_MSB:motor_status_pkg::STATE_LSB] =
          snap_bus.state_code; // [R4] [R5]
        read_value[motor_status_pkg::SELFTEST_BIT] = snap_bus.selftest_fail_flag; // [R6]
        read_value[motor_status_pkg::MOTOR_SPEED_MSB:motor_status_pkg::MOTOR_SPEED_LSB] =
          snap_bus.motor_speed; // [R7]
      end
      motor_status_pkg::sel_status_three: begin
        read_value[motor_status_pkg::CURRENT_MSB:motor_status_pkg::CURRENT_LSB] =
          snap_bus.bus_current_reading; // [R10]
        read_value[motor_status_pkg::POWER_MSB:motor_status_pkg::POWER_LSB] =
          snap_bus.input_power_reading; // [R11]
      end
      motor_status_pkg::sel_irq_status: begin
        read_value[2:0] = irq_status_reg;
      end
      motor_status_pkg::sel_irq_mask: begin
        read_value[2:0] = irq_mask_reg;
      end
      default: begin
        read_value = motor_status_pkg::STATUS_RESET; // [R12]
      end
    endcase
  end

  // Read data stand for exactly one cycle so a stale word is never mistaken for an answer.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= motor_status_pkg::STATUS_RESET; // [R8]
    end else if (reg_rd) begin
      reg_rdata <= read_value;
    end else begin
      reg_rdata <= motor_status_pkg::READ_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // A new event in the clearing cycle wins, so no event is lost to a racing clear.
  genvar gi;
  generate
    for (gi = 0; gi < motor_status_pkg::EVT_COUNT; gi++) begin : g_irq_bit
      always_ff @(posedge core_clk) begin
        if (reset) begin
          irq_status_reg[gi] <= 1'b0;
        end else if (snap_bus.event_pulse[gi]) begin
          irq_status_reg[gi] <= 1'b1;
        end else if (clear_hit && reg_wdata[gi]) begin
          irq_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_mask_reg <= motor_status_pkg::IRQ_RESET;
    end else if (reg_wr && wr_sel == motor_status_pkg::sel_irq_mask) begin
      irq_mask_reg <= reg_wdata[2:0];
    end
  end

  // The level lags the status bits by one cycle; this keeps the output a flip-flop.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  sequence s_read_one;
    reg_rd && rd_sel == motor_status_pkg::sel_status_one;
  endsequence

  sequence s_read_two;
    reg_rd && rd_sel == motor_status_pkg::sel_status_two;
  endsequence

  sequence s_read_three;
    reg_rd && rd_sel == motor_status_pkg::sel_status_three;
  endsequence

  property p_voltage_field;
    @(posedge core_clk) disable iff (reset)
      s_read_one |=> reg_rdata[31:16] == $past(snap_bus.supply_voltage_reading);
  endproperty
  a_voltage_field: assert property (p_voltage_field) // [R1]
    else $error("supply voltage field wrong");

  property p_speed_cmd_field;
    @(posedge core_clk) disable iff (reset)
      s_read_one |=> reg_rdata[15:1] == $past(speed_request, 2);
  endproperty
  a_speed_cmd_field: assert property (p_speed_cmd_field) // [R2]
    else $error("speed request field wrong");

  property p_serial_entry_bit;
    @(posedge core_clk) disable iff (reset)
      s_read_one |=> reg_rdata[0] == $past(snap_bus.serial_entry);
  endproperty
  a_serial_entry_bit: assert property (p_serial_entry_bit) // [R3]
    else $error("serial entry bit wrong");

  property p_state_field;
    @(posedge core_clk) disable iff (reset)
      s_read_two |=> reg_rdata[31:28] == motor_status_pkg::normalise_state($past(state_code, 2));
  endproperty
  a_state_field: assert property (p_state_field) // [R4]
    else $error("state field wrong");

  property p_state_legal;
    @(posedge core_clk) disable iff (reset)
      s_read_two |=> reg_rdata[31:28] != 4'hb && reg_rdata[31:28] != 4'he;
  endproperty
  a_state_legal: assert property (p_state_legal) // [R5]
    else $error("unlisted state code read back");

  property p_selftest_bit;
    @(posedge core_clk) disable iff (reset)
      s_read_two |=> reg_rdata[17] == $past(selftest_fail_flag, 2)
        && reg_rdata[27:18] == 10'h000 && reg_rdata[16] == 1'b0;
  endproperty
  a_selftest_bit: assert property (p_selftest_bit) // [R6]
    else $error("self-test bit or reserved bits wrong");

  property p_motor_speed_field;
    @(posedge core_clk) disable iff (reset)
      s_read_two |=> reg_rdata[15:0] == $past(motor_speed, 2);
  endproperty
  a_motor_speed_field: assert property (p_motor_speed_field) // [R7]
    else $error("motor speed field wrong");

  property p_reset_zero;
    @(posedge core_clk)
      reset |=> reg_rdata == 32'h0000_0000 && !irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [R8]
    else $error("outputs not zero after reset");

  property p_first_read_zero;
    @(posedge core_clk)
      reset ##1 (!reset && reg_rd && rd_sel != motor_status_pkg::sel_none) |=> reg_rdata == 32'h0;
  endproperty
  a_first_read_zero: assert property (p_first_read_zero) // [R8]
    else $error("register not zero right after reset");

  property p_current_field;
    @(posedge core_clk) disable iff (reset)
      s_read_three |=> reg_rdata[31:16] == $past(bus_current_reading, 2);
  endproperty
  a_current_field: assert property (p_current_field) // [R10]
    else $error("bus current field wrong");

  property p_power_field;
    @(posedge core_clk) disable iff (reset)
      s_read_three |=> reg_rdata[15:0] == $past(input_power_reading, 2);
  endproperty
  a_power_field: assert property (p_power_field) // [R11]
    else $error("input power field wrong");

  property p_no_read_no_data;
    @(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_no_read_no_data: assert property (p_no_read_no_data) // [R12]
    else $error("read data outside the answer cycle");

  property p_unmapped_zero;
    @(posedge core_clk) disable iff (reset)
      reg_rd && rd_sel == motor_status_pkg::sel_none |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // [R12]
    else $error("unmapped read not zero");

  property p_event_wins;
    @(posedge core_clk) disable iff (reset)
      snap_bus.event_pulse[0] && clear_hit |=> irq_status_reg[0];
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("event lost to clear");

  property p_irq_level;
    @(posedge core_clk) disable iff (reset)
      ##1 irq == |($past(irq_status_reg) & $past(irq_mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level wrong");

  sequence s_read_irq_status;
    reg_rd && rd_sel == motor_status_pkg::sel_irq_status;
  endsequence

  sequence s_read_irq_mask;
    reg_rd && rd_sel == motor_status_pkg::sel_irq_mask;
  endsequence

  sequence s_mask_write;
    reg_wr && wr_sel == motor_status_pkg::sel_irq_mask;
  endsequence

  property p_irq_status_read;
    @(posedge core_clk) disable iff (reset)
      s_read_irq_status |=> reg_rdata == {29'h0000_0000, $past(irq_status_reg)};
  endproperty
  a_irq_status_read: assert property (p_irq_status_read)
    else $error("interrupt status read back wrong");

  property p_irq_mask_read;
    @(posedge core_clk) disable iff (reset)
      s_read_irq_mask |=> reg_rdata == {29'h0000_0000, $past(irq_mask_reg)};
  endproperty
  a_irq_mask_read: assert property (p_irq_mask_read)
    else $error("interrupt mask read back wrong");

  property p_mask_write;
    @(posedge core_clk) disable iff (reset)
      s_mask_write |=> irq_mask_reg == $past(reg_wdata[2:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write did not land");

  property p_mask_hold;
    @(posedge core_clk) disable iff (reset)
      !(reg_wr && wr_sel == motor_status_pkg::sel_irq_mask) |=> $stable(irq_mask_reg);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a mask write");

  property p_event_sets;
    @(posedge core_clk) disable iff (reset)
      |snap_bus.event_pulse |=>
        (irq_status_reg & $past(snap_bus.event_pulse)) == $past(snap_bus.event_pulse);
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event did not set its status bit");

  property p_status_sticky;
    @(posedge core_clk) disable iff (reset)
      !clear_hit |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg);
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a clear");

  property p_clear_works;
    @(posedge core_clk) disable iff (reset)
      clear_hit |=>
        (irq_status_reg & $past(reg_wdata[2:0]) & ~$past(snap_bus.event_pulse)) == 3'h0;
  endproperty
  a_clear_works: assert property (p_clear_works)
    else $error("status bit not cleared by a written one");

  property p_state_event;
    @(posedge core_clk) disable iff (reset)
      ##1 snap_bus.event_pulse[motor_status_pkg::EVT_STATE_CHANGE] ==
        $changed(snap_bus.state_code);
  endproperty
  a_state_event: assert property (p_state_event) // [R4]
    else $error("state change event wrong");

  property p_selftest_event;
    @(posedge core_clk) disable iff (reset)
      ##1 snap_bus.event_pulse[motor_status_pkg::EVT_SELFTEST_FAIL] ==
        $rose(snap_bus.selftest_fail_flag);
  endproperty
  a_selftest_event: assert property (p_selftest_event) // [R6]
    else $error("self-test failure event wrong");

  property p_serial_event;
    @(posedge core_clk) disable iff (reset)
      ##1 snap_bus.event_pulse[motor_status_pkg::EVT_SERIAL_ENTRY] ==
        $rose(snap_bus.serial_entry);
  endproperty
  a_serial_event: assert property (p_serial_event) // [R3]
    else $error("serial entry event wrong");

endmodule
`default_nettype wire

// File: common/motor_status_pkg.sv
package motor_status_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;

  // Offsets are register indexes; the byte address is four times the index.
  localparam logic [9:0] STATUS_ONE_INDEX = 10'h0e4;
  localparam logic [9:0] STATUS_TWO_INDEX = 10'h0ea;
  localparam logic [9:0] STATUS_THREE_INDEX = 10'h0ec;
  localparam logic [9:0] IRQ_STATUS_INDEX = 10'h0f0;
  localparam logic [9:0] IRQ_MASK_INDEX = 10'h0f1;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  localparam int VOLT_MSB = 31;
  localparam int VOLT_LSB = 16;
  localparam int SPEED_CMD_MSB = 15;
  localparam int SPEED_CMD_LSB = 1;
  localparam int SERIAL_ENTRY_BIT = 0;
  localparam int STATE_MSB = 31;
  localparam int STATE_LSB = 28;
  localparam int SELFTEST_BIT = 17;
  localparam int MOTOR_SPEED_MSB = 15;
  localparam int MOTOR_SPEED_LSB = 0;
  localparam int CURRENT_MSB = 31;
  localparam int CURRENT_LSB = 16;
  localparam int POWER_MSB = 15;
  localparam int POWER_LSB = 0;

  localparam logic [3:0] STATE_SYSTEM_IDLE = 4'h0;
  localparam logic [3:0] STATE_MOTOR_START = 4'h1;
  localparam logic [3:0] STATE_RUN = 4'h2;
  localparam logic [3:0] STATE_SYSTEM_INIT = 4'h3;
  localparam logic [3:0] STATE_POSITION_DETECT = 4'h4;
  localparam logic [3:0] STATE_ALIGN = 4'h5;
  localparam logic [3:0] STATE_MOTOR_IDLE = 4'h6;
  localparam logic [3:0] STATE_STOP = 4'h7;
  localparam logic [3:0] STATE_FAULT = 4'h8;
  localparam logic [3:0] STATE_DIRECTION = 4'h9;
  localparam logic [3:0] STATE_SENSOR_ALIGN = 4'ha;
  localparam logic [3:0] STATE_COAST = 4'hc;
  localparam logic [3:0] STATE_BRAKING = 4'hd;
  localparam logic [3:0] STATE_NOT_APPLICABLE = 4'hf;

  localparam int EVT_STATE_CHANGE = 0;
  localparam int EVT_SELFTEST_FAIL = 1;
  localparam int EVT_SERIAL_ENTRY = 2;
  localparam int EVT_COUNT = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  typedef enum logic [2:0] {
    sel_none, sel_status_one, sel_status_two, sel_status_three, sel_irq_status, sel_irq_mask
  } reg_sel_t;

  function automatic reg_sel_t decode_reg(input logic [11:0] addr);
    reg_sel_t sel;
    sel = sel_none;
    if (addr == {STATUS_ONE_INDEX, 2'b00}) begin
      sel = sel_status_one;
    end else if (addr == {STATUS_TWO_INDEX, 2'b00}) begin
      sel = sel_status_two;
    end else if (addr == {STATUS_THREE_INDEX, 2'b00}) begin
      sel = sel_status_three;
    end else if (addr == {IRQ_STATUS_INDEX, 2'b00}) begin
      sel = sel_irq_status;
    end else if (addr == {IRQ_MASK_INDEX, 2'b00}) begin
      sel = sel_irq_mask;
    end
    return sel;
  endfunction

  // Codes 0xb and 0xe have no meaning and are reported as not applicable.
  function automatic logic [3:0] normalise_state(input logic [3:0] code);
    logic [3:0] res;
    res = code;
    if (code == 4'hb || code == 4'he) begin
      res = STATE_NOT_APPLICABLE;
    end
    return res;
  endfunction

endpackage

// File: common/status_snapshot_if.sv
`timescale 1ns/1ps
`default_nettype none
interface status_snapshot_if;
  logic [15:0] supply_voltage_reading;
  logic [14:0] speed_request;
  logic serial_entry;
  logic [3:0] state_code;
  logic selftest_fail_flag;
  logic [15:0] motor_speed;
  logic [15:0] bus_current_reading;
  logic [15:0] input_power_reading;
  logic [2:0] event_pulse;

  modport producer (
    output supply_voltage_reading, speed_request, serial_entry, state_code,
    output selftest_fail_flag, motor_speed, bus_current_reading, input_power_reading, event_pulse
  );
  modport consumer (
    input supply_voltage_reading, speed_request, serial_entry, state_code,
    input selftest_fail_flag, motor_speed, bus_current_reading, input_power_reading, event_pulse
  );
endinterface
`default_nettype wire

// File: src/status_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module status_sampler (
  input wire logic core_clk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic [15:0] supply_voltage_reading, // supply in tenths of a volt
  input wire logic [14:0] speed_request, // decoded speed request
  input wire logic serial_entry, // serial mode entered by pin sequence
  input wire logic [3:0] state_code, // raw control state code
  input wire logic selftest_fail_flag, // self-test failed
  input wire logic [15:0] motor_speed, // electrical speed in tenths of a hertz
  input wire logic [15:0] bus_current_reading, // bus current in 1/256 A
  input wire logic [15:0] input_power_reading, // input power in 1/64 W
  status_snapshot_if.producer bus // registered snapshot and events
);

  ////////////////////////////////////////////////////////////////////////////////

  // One snapshot per cycle keeps every field of a register from the same instant.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus.supply_voltage_reading <= 16'h0000;
      bus.speed_request <= 15'h0000;
      bus.serial_entry <= 1'b0;
      bus.state_code <= 4'h0;
      bus.selftest_fail_flag <= 1'b0;
      bus.motor_speed <= 16'h0000;
      bus.bus_current_reading <= 16'h0000;
      bus.input_power_reading <= 16'h0000;
    end else begin
      bus.supply_voltage_reading <= supply_voltage_reading;
      bus.speed_request <= speed_request;
      bus.serial_entry <= serial_entry;
      bus.state_code <= motor_status_pkg::normalise_state(state_code); // [R4] [R5]
      bus.selftest_fail_flag <= selftest_fail_flag;
      bus.motor_speed <= motor_speed;
      bus.bus_current_reading <= bus_current_reading;
      bus.input_power_reading <= input_power_reading;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus.event_pulse <= 3'h0;
    end else begin
      bus.event_pulse[motor_status_pkg::EVT_STATE_CHANGE] <=
        motor_status_pkg::normalise_state(state_code) != bus.state_code;
      bus.event_pulse[motor_status_pkg::EVT_SELFTEST_FAIL] <=
        selftest_fail_flag && !bus.selftest_fail_flag;
      bus.event_pulse[motor_status_pkg::EVT_SERIAL_ENTRY] <= serial_entry && !bus.serial_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  property p_state_follows;
    @(posedge core_clk) disable iff (reset)
      ##1 bus.state_code == motor_status_pkg::normalise_state($past(state_code));
  endproperty
  a_state_follows: assert property (p_state_follows) // [R4]
    else $error("state code snapshot does not follow the input");

  property p_state_unlisted;
    @(posedge core_clk) disable iff (reset)
      (state_code == 4'hb || state_code == 4'he) |=> bus.state_code == 4'hf;
  endproperty
  a_state_unlisted: assert property (p_state_unlisted) // [R5]
    else $error("unlisted state code not reported as not applicable");

endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic [15:0] v_in = 16'h0000;
  logic [14:0] spd_in = 15'h0000;
  logic ser_in = 1'b0;
  logic [3:0] st_in = 4'h0;
  logic fail_in = 1'b0;
  logic [15:0] ms_in = 16'h0000;
  logic [15:0] cur_in = 16'h0000;
  logic [15:0] pow_in = 16'h0000;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic churn = 1'b0;
  logic [31:0] seed = 32'h0000_0034;
  logic [31:0] pend[$];
  logic [31:0] want;
  logic [11:0] amap [6] = '{12'h390, 12'h3a8, 12'h3b0, 12'h3c0, 12'h3c4, 12'h398};
  logic [15:0] m_v, m_ms, m_cur, m_pow;
  logic [14:0] m_spd;
  logic m_ser, m_fail, m_irq;
  logic [3:0] m_code;
  logic [2:0] m_ev, m_stat, m_mask;

  motor_system_status_regs i_motor_system_status_regs (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .supply_voltage_reading(v_in), .speed_request(spd_in), .serial_entry(ser_in),
    .state_code(st_in), .selftest_fail_flag(fail_in), .motor_speed(ms_in),
    .bus_current_reading(cur_in), .input_power_reading(pow_in)
  );

  always #2.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    logic [31:0] r;
    r = x;
    for (int i = 0; i < 8; i++) begin
      r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    end
    return r;
  endfunction

  // Codes without a meaning collapse to not applicable.
  function automatic logic [3:0] norm(input logic [3:0] c);
    return (c == 4'hb || c == 4'he) ? 4'hf : c;
  endfunction

  // Expected read data from the model as it stood before the read edge.
  function automatic logic [31:0] mexp(input logic [11:0] a);
    case (a)
      12'h390: return {m_v, m_spd, m_ser};
      12'h3a8: return {m_code, 10'h000, m_fail, 1'b0, m_ms};
      12'h3b0: return {m_cur, m_pow};
      12'h3c0: return {29'h0000_0000, m_stat};
      12'h3c4: return {29'h0000_0000, m_mask};
      default: return 32'h0000_0000;
    endcase
  endfunction

  always @(posedge core_clk) begin
    if (reset) begin
      {m_v, m_spd, m_ser, m_code, m_fail, m_ms, m_cur, m_pow} <= '0;
      {m_ev, m_stat, m_mask, m_irq} <= '0;
    end else begin
      {m_v, m_spd, m_ser, m_fail, m_ms, m_cur, m_pow} <=
        {v_in, spd_in, ser_in, fail_in, ms_in, cur_in, pow_in};
      m_code <= norm(st_in);
      m_ev <= {ser_in & ~m_ser, fail_in & ~m_fail, norm(st_in) != m_code};
      // A clear landing with a new event leaves the bit set.
      m_stat <= (m_stat & ~((reg_wr && reg_addr == 12'h3c0) ? reg_wdata[2:0] : 3'h0)) | m_ev;
      m_irq <= |(m_stat & m_mask);
      if (reg_wr && reg_addr == 12'h3c4) begin
        m_mask <= reg_wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rand_inputs();
    seed = lfsr(seed);
    v_in <= seed[15:0];
    spd_in <= seed[30:16];
    ser_in <= seed[31];
    seed = lfsr(seed);
    ms_in <= seed[15:0];
    st_in <= seed[19:16];
    fail_in <= seed[20];
    seed = lfsr(seed);
    cur_in <= seed[15:0];
    pow_in <= seed[31:16];
  endtask

  task automatic rd(input logic [11:0] a);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge core_clk);
    pend.push_back(mexp(a));
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Read data must stand one cycle only and be zero otherwise.
  always @(negedge core_clk) begin
    if (cyc > 0) begin
      want = (pend.size() > 0) ? pend.pop_front() : 32'h0000_0000;
      check(reg_rdata, want);
      check({31'h0000_0000, irq}, {31'h0000_0000, m_irq});
    end
  end

  always @(posedge core_clk) begin
    if (churn) begin
      rand_inputs();
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      print_verdict();
    end
  end

  // Writes go only to status, interrupt and mask registers; unmapped places are read only.
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(amap[i]);
    end
    wr(12'h3c4, 32'h0000_0007);
    for (int i = 0; i < 16; i++) begin
      st_in <= i[3:0];
      idle(3);
      rd(12'h3a8);
      rd(12'h3c0);
      wr(12'h3c0, 32'h0000_0001);
    end
    wr(12'h3c4, 32'h0000_0000);
    fail_in <= 1'b1;
    ser_in <= 1'b1;
    idle(4);
    rd(12'h3c0);
    rd(12'h390);
    wr(12'h3c4, 32'h0000_0006);
    idle(3);
    wr(12'h3c0, 32'h0000_0007);
    idle(3);
    churn <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      rd(amap[i % 6]);
      wr(amap[i % 3], seed);
      rd(amap[(i + 1) % 3]);
      if (i % 4 == 0) begin
        wr(12'h3c0, {29'h0000_0000, seed[2:0]});
      end
      if (i % 10 == 0) begin
        rd(12'h391);
      end
    end
    churn <= 1'b0;
    idle(4);
    print_verdict();
  end
endmodule
`default_nettype wire
